// >>> verilog/sram_port_consts.vh
// Shared constants for the pipelined burst SRAM port and its write queue.
// Assumes inclusion by bare name from files under verilog/.
`ifndef SRAM_PORT_CONSTS_VH
`define SRAM_PORT_CONSTS_VH

// ============================================================
// Array geometry
`define ADDR_W 21
`define LOW_W 2
`define DATA_W 36
`define LANES 4
`define LANE_W 9
`define MASK_W 4
`define MEM_LAST 21'h1F_FFFF

// ============================================================
// Write queue layout: {address, data, lane mask}
`define FIFO_DEPTH 8
`define Q_W 61
`define Q_MASK_LSB 0
`define Q_DATA_LSB 4
`define Q_ADDR_LSB 40

// ============================================================
// Reset and fixed values
`define ADDR_ZERO 21'h00_0000
`define DATA_ZERO 36'h0_0000_0000
`define MASK_NONE 4'h0
`define LOW_ZERO 2'h0
`define LOW_ONE 2'h1

`endif

// >>> verilog/burst_fifo.v
// Parameterised first-in first-out queue with valid and ready on both sides.
// Assumes a single clock, a synchronous active-low reset and DEPTH a power of two.
module burst_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8
) (
    // Clock and reset.
    input wire clk_in,
    input wire rst_n_in,
    // Filling side.
    input wire in_valid_in,
    output reg in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // Draining side.
    output reg out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

    localparam PTR_W = $clog2(DEPTH);
    localparam CNT_W = PTR_W + 1;
    localparam [CNT_W-1:0] FULL_COUNT = DEPTH;
    localparam [CNT_W-1:0] ONE_COUNT = 1;
    localparam [PTR_W-1:0] ONE_PTR = 1;

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [CNT_W-1:0] count;
    reg [CNT_W-1:0] next_count;
    wire push;
    wire pop;

    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_data_out = store[rd_ptr];

    always @* begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + ONE_COUNT;
        end else if (pop && !push) begin
            next_count = count - ONE_COUNT;
        end
    end

    // ============================================================
    // Storage is not reset; only the pointers, the count and the flags are.
    always @(posedge clk_in) begin
        if (push) begin
            store[wr_ptr] <= in_data_in;
        end
    end

    // ============================================================
    // Flags are registered from the next count, so full and empty are exact.
    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count <= {CNT_W{1'b0}};
            in_ready_out <= 1'b0;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + ONE_PTR;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + ONE_PTR;
            end
            count <= next_count;
            in_ready_out <= (next_count != FULL_COUNT);
            out_valid_out <= (next_count != {CNT_W{1'b0}});
        end
    end

endmodule

// >>> verilog/pipelined_burst_sram_port.v
// Pipelined, no-turnaround burst SRAM port with a queued array write path.
// Assumes every input is synchronous to CLK_IN except the output enable and the order strap.
//
// Notes on behaviour
// - Every synchronous input is captured in registers on the rising clock edge.
// - Read or write data for an access occurs exactly two cycles after its address.
// - Clock qualify high freezes every pipeline register and ignores all access inputs; queued writes still drain.
// - Any inactive chip select with load low starts nothing and stops the burst.
// - Accesses already in the pipeline still complete after a deselect.
// - Data bus floats two cycles after a deselect or a write start.
// - A two-bit burst counter steps through four addresses from one address, then wraps.
// - The order strap chooses linear or interleaved burst sequence.
// - Load low loads a new address; load high advances the burst counter.
// - Output enable high disables the data drivers at once, clock independent.
// - Reads and writes may alternate on consecutive cycles without idle cycles.
// - Read data leaves through internally timed output registers.
// - Each byte lane has its own write select; all active writes whole words.
// - One read/write input sampled with the address selects read or write.
// - Three chip selects together select the device for depth expansion.
// - Lane write selects are active low, write-qualified, and cover byte plus parity.
// - Selected only with first and third selects low and second high.
// - Strap high selects interleaved, low linear; it must stay fixed.
`include "sram_port_consts.vh"

module pipelined_burst_sram_port (
    // Clock and reset.
    input wire CLK_IN,
    input wire RST_N_IN,
    // Address and access control.
    input wire [`ADDR_W-1:0] ADDR_IN,
    input wire CLOCK_QUALIFY_N_IN,
    input wire CHIP_SELECT_FIRST_N_IN,
    input wire CHIP_SELECT_SECOND_IN,
    input wire CHIP_SELECT_THIRD_N_IN,
    input wire LOAD_OR_ADVANCE_IN,
    input wire READ_NOT_WRITE_IN,
    input wire [`MASK_W-1:0] BYTE_LANE_WRITE_N_IN,
    // Asynchronous output enable, synchronous sleep request and static order strap.
    input wire OUTPUT_ENABLE_N_IN,
    input wire SLEEP_REQUEST_IN,
    input wire BURST_ORDER_IN,
    // Shared data bus, each lane a byte with its parity lane on top.
    input wire [`DATA_W-1:0] DATA_IN,
    output reg [`DATA_W-1:0] DATA_OUT,
    output wire DATA_OE_OUT,
    // Write queue status.
    output wire WRITE_QUEUE_READY_OUT
);

    // ============================================================
    // Helpers

    // Replaces the lanes whose mask bit is set, byte and parity together.
    function [`DATA_W-1:0] merge_lanes;
        input [`DATA_W-1:0] old_word;
        input [`DATA_W-1:0] new_word;
        input [`MASK_W-1:0] mask;
        integer k;
        begin
            merge_lanes = old_word;
            for (k = 0; k < `LANES; k = k + 1) begin
                if (mask[k]) begin
                    merge_lanes[k*`LANE_W +: `LANE_W] = new_word[k*`LANE_W +: `LANE_W];
                end
            end
        end
    endfunction

    // Low address bits of a burst beat; only these two bits ever move.
    function [`LOW_W-1:0] burst_low;
        input [`LOW_W-1:0] start;
        input [`LOW_W-1:0] count;
        input interleaved;
        begin
            if (interleaved) begin
                burst_low = start ^ count;
            end else begin
                burst_low = start + count;
            end
        end
    endfunction

    // ============================================================
    // Storage and state

    reg [`DATA_W-1:0] mem [0:`MEM_LAST];

    reg burst_active;
    reg burst_write;
    reg [`LOW_W-1:0] burst_cnt;
    reg [`ADDR_W-1:0] load_addr;

    reg s1_valid;
    reg s1_write;
    reg [`ADDR_W-1:0] s1_addr;
    reg [`MASK_W-1:0] s1_mask;
    reg s2_valid;
    reg s2_write;
    reg [`ADDR_W-1:0] s2_addr;
    reg [`MASK_W-1:0] s2_mask;
    reg drive;

    reg selected;
    reg next_burst_active;
    reg next_burst_write;
    reg [`LOW_W-1:0] next_burst_cnt;
    reg [`ADDR_W-1:0] next_load_addr;
    reg next_s1_valid;
    reg next_s1_write;
    reg [`ADDR_W-1:0] next_s1_addr;
    reg [`MASK_W-1:0] next_s1_mask;
    reg [`DATA_W-1:0] read_word;

    wire advance;
    wire q_in_valid;
    wire q_in_ready;
    wire [`Q_W-1:0] q_in_data;
    wire q_out_valid;
    wire q_out_ready;
    wire [`Q_W-1:0] q_out_data;
    wire [`ADDR_W-1:0] q_addr;
    wire [`DATA_W-1:0] q_data;
    wire [`MASK_W-1:0] q_mask;

    // A full write queue holds the whole pipeline exactly as clock qualify high
    // does; the controller must watch the ready output to keep its own timing.
    assign advance = ~CLOCK_QUALIFY_N_IN & q_in_ready;

    // The drivers stay registered; only the asynchronous enable is combined
    // after the flop so that it can cut the bus without a clock.
    assign DATA_OE_OUT = drive & ~OUTPUT_ENABLE_N_IN;
    assign WRITE_QUEUE_READY_OUT = q_in_ready;

    // ============================================================
    // Address phase: selection, load and burst advance

    always @* begin
        selected = ~CHIP_SELECT_FIRST_N_IN & CHIP_SELECT_SECOND_IN & ~CHIP_SELECT_THIRD_N_IN;
        next_burst_active = burst_active;
        next_burst_write = burst_write;
        next_burst_cnt = burst_cnt;
        next_load_addr = load_addr;
        next_s1_valid = 1'b0;
        next_s1_write = burst_write;
        next_s1_addr = s1_addr;
        next_s1_mask = `MASK_NONE;
        if (!LOAD_OR_ADVANCE_IN) begin
            if (selected) begin
                next_burst_active = 1'b1;
                next_burst_cnt = `LOW_ZERO;
                next_load_addr = ADDR_IN;
                next_burst_write = ~READ_NOT_WRITE_IN;
                next_s1_valid = 1'b1;
                next_s1_write = ~READ_NOT_WRITE_IN;
                next_s1_addr = ADDR_IN;
            end else begin
                next_burst_active = 1'b0;
            end
        end else if (burst_active) begin
            next_burst_cnt = burst_cnt + `LOW_ONE;
            next_s1_valid = 1'b1;
            // Upper bits come from the loaded address, so the burst wraps
            // inside its four-word group.
            next_s1_addr = {load_addr[`ADDR_W-1:`LOW_W],
                            burst_low(load_addr[`LOW_W-1:0], next_burst_cnt, BURST_ORDER_IN)};
        end
        if (next_s1_valid && next_s1_write) begin
            next_s1_mask = ~BYTE_LANE_WRITE_N_IN;
        end
    end

    // ============================================================
    // Read forwarding

    assign q_addr = q_out_data[`Q_ADDR_LSB +: `ADDR_W];
    assign q_data = q_out_data[`Q_DATA_LSB +: `DATA_W];
    assign q_mask = q_out_data[`Q_MASK_LSB +: `MASK_W];

    // The array lags the bus by the queue, so a read merges the queue head and
    // the write whose data is on the bus right now. Deeper queue entries only
    // exist while sleep holds the drain, when no reads are expected.
    always @* begin
        read_word = mem[s1_addr];
        if (q_out_valid && q_addr == s1_addr) begin
            read_word = merge_lanes(read_word, q_data, q_mask);
        end
        if (s2_valid && s2_write && s2_addr == s1_addr) begin
            read_word = merge_lanes(read_word, DATA_IN, s2_mask);
        end
    end

    // ============================================================
    // Pipeline registers

    always @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            burst_active <= 1'b0;
            burst_write <= 1'b0;
            burst_cnt <= `LOW_ZERO;
            load_addr <= `ADDR_ZERO;
            s1_valid <= 1'b0;
            s1_write <= 1'b0;
            s1_addr <= `ADDR_ZERO;
            s1_mask <= `MASK_NONE;
            s2_valid <= 1'b0;
            s2_write <= 1'b0;
            s2_addr <= `ADDR_ZERO;
            s2_mask <= `MASK_NONE;
            drive <= 1'b0;
            DATA_OUT <= `DATA_ZERO;
        end else if (advance) begin
            burst_active <= next_burst_active;
            burst_write <= next_burst_write;
            burst_cnt <= next_burst_cnt;
            load_addr <= next_load_addr;
            s1_valid <= next_s1_valid;
            s1_write <= next_s1_write;
            s1_addr <= next_s1_addr;
            s1_mask <= next_s1_mask;
            // Stage two carries on whatever stage one held, selected or not.
            s2_valid <= s1_valid;
            s2_write <= s1_write;
            s2_addr <= s1_addr;
            s2_mask <= s1_mask;
            if (s1_valid && !s1_write) begin
                DATA_OUT <= read_word;
                drive <= 1'b1;
            end else begin
                drive <= 1'b0;
            end
        end
    end

    // ============================================================
    // Write path: bus data is captured into the queue in the data cycle

    assign q_in_valid = s2_valid & s2_write & ~CLOCK_QUALIFY_N_IN;
    assign q_in_data = {s2_addr, DATA_IN, s2_mask};

    // Sleep only pauses the array; queued writes are kept and resume later.
    assign q_out_ready = ~SLEEP_REQUEST_IN;

    burst_fifo #(
        .WIDTH(`Q_W),
        .DEPTH(`FIFO_DEPTH)
    ) write_queue (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .in_valid_in(q_in_valid),
        .in_ready_out(q_in_ready),
        .in_data_in(q_in_data),
        .out_valid_out(q_out_valid),
        .out_ready_in(q_out_ready),
        .out_data_out(q_out_data)
    );

    always @(posedge CLK_IN) begin
        if (q_out_valid && q_out_ready) begin
            mem[q_addr] <= merge_lanes(mem[q_addr], q_data, q_mask);
        end
    end

endmodule

// >>> tb/sram_port_monitor.sv
// Concurrent checks on the pins of the pipelined burst SRAM port.
// Assumes it is bound to the port's top module; every check uses the rising clock edge.
`include "sram_port_consts.vh"
module sram_port_monitor (
    // Clock and reset.
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Access control.
    input wire logic CLOCK_QUALIFY_N_IN,
    input wire logic CHIP_SELECT_FIRST_N_IN,
    input wire logic CHIP_SELECT_SECOND_IN,
    input wire logic CHIP_SELECT_THIRD_N_IN,
    input wire logic LOAD_OR_ADVANCE_IN,
    input wire logic READ_NOT_WRITE_IN,
    input wire logic OUTPUT_ENABLE_N_IN,
    // Device outputs.
    input wire logic [`DATA_W-1:0] DATA_OUT,
    input wire logic DATA_OE_OUT,
    input wire logic WRITE_QUEUE_READY_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic adv;
    logic sel;
    logic oe_ok;
    assign adv = !CLOCK_QUALIFY_N_IN && WRITE_QUEUE_READY_OUT;
    assign sel = !CHIP_SELECT_FIRST_N_IN && CHIP_SELECT_SECOND_IN && !CHIP_SELECT_THIRD_N_IN;
    // A high output enable may legally mask the drive at any sample.
    assign oe_ok = DATA_OE_OUT || OUTPUT_ENABLE_N_IN;
    // ============================================================
    // Pipeline steps
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    sequence s_read;
        adv && !LOAD_OR_ADVANCE_IN && sel && READ_NOT_WRITE_IN;
    endsequence
    sequence s_write;
        adv && !LOAD_OR_ADVANCE_IN && sel && !READ_NOT_WRITE_IN;
    endsequence
    sequence s_desel;
        adv && !LOAD_OR_ADVANCE_IN && !sel;
    endsequence
    sequence s_step;
        adv && !OUTPUT_ENABLE_N_IN;
    endsequence
    a_read_drives_bus: assert property (s_read ##1 s_step |=> oe_ok)
        else $error("read data not driven two edges after its address");
    a_write_floats_bus: assert property (s_write ##1 adv |=> !DATA_OE_OUT)
        else $error("bus driven in a write data cycle");
    a_desel_floats_bus: assert property (s_desel ##1 adv |=> !DATA_OE_OUT)
        else $error("bus driven two edges after a deselect");
    a_desel_completes: assert property (s_read ##1 s_desel |=> oe_ok and (adv |=> !DATA_OE_OUT))
        else $error("pending read lost or burst kept after deselect");
    a_burst_beat_read: assert property (s_read ##1 (adv && LOAD_OR_ADVANCE_IN) ##1 s_step |=> oe_ok)
        else $error("burst advance beat gave no read data");
    a_no_turnaround: assert property (s_write ##1 s_read |=> !DATA_OE_OUT and (s_step |=> oe_ok))
        else $error("write to read turnaround needs an idle cycle");
    a_stall_holds_data: assert property (!adv |=> $stable(DATA_OUT))
        else $error("read data changed while the pipeline was stalled");
    a_stall_holds_drive: assert property ((!adv && !OUTPUT_ENABLE_N_IN) ##1 !OUTPUT_ENABLE_N_IN
        |-> $stable(DATA_OE_OUT))
        else $error("drive enable changed while the pipeline was stalled");
    a_oe_masks_drive: assert property (OUTPUT_ENABLE_N_IN |-> !DATA_OE_OUT)
        else $error("bus driven with the output enable high");
endmodule

bind pipelined_burst_sram_port sram_port_monitor u_monitor (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .CLOCK_QUALIFY_N_IN(CLOCK_QUALIFY_N_IN), .CHIP_SELECT_FIRST_N_IN(CHIP_SELECT_FIRST_N_IN),
    .CHIP_SELECT_SECOND_IN(CHIP_SELECT_SECOND_IN), .CHIP_SELECT_THIRD_N_IN(CHIP_SELECT_THIRD_N_IN),
    .LOAD_OR_ADVANCE_IN(LOAD_OR_ADVANCE_IN), .READ_NOT_WRITE_IN(READ_NOT_WRITE_IN),
    .OUTPUT_ENABLE_N_IN(OUTPUT_ENABLE_N_IN), .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT),
    .WRITE_QUEUE_READY_OUT(WRITE_QUEUE_READY_OUT));

// >>> tb/sram_ctrl_model.sv
// Behavioural memory controller at the far side of the SRAM port's data bus.
// Assumes the bench issues beats and flags which of them carry write or read data.
`include "sram_port_consts.vh"
module sram_ctrl_model (
    // Clock and pipeline qualifiers.
    input wire logic clk_in,
    input wire logic qualify_n_in,
    input wire logic ready_in,
    // Beat issued in this cycle.
    input wire logic write_beat_in,
    input wire logic read_beat_in,
    input wire logic [`DATA_W-1:0] write_data_in,
    // Device side of the shared bus.
    input wire logic [`DATA_W-1:0] dev_data_in,
    input wire logic dev_oe_in,
    output wire logic [`DATA_W-1:0] bus_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`DATA_W+1:0] stage0 = 38'h00_0000_0000;
    logic [`DATA_W+1:0] stage1 = 38'h00_0000_0000;
    logic [`DATA_W-1:0] held = `DATA_ZERO;
    logic [`DATA_W-1:0] last = `DATA_ZERO;
    logic driving = 1'b0;
    logic [`DATA_W-1:0] rdq [$];
    // ============================================================
    // Data pipeline
    // Beats move only on accepted edges, so data lines up two accepted edges after its address.
    always @(posedge clk_in) begin
        last <= bus_out;
        if (!qualify_n_in && ready_in) begin
            if (stage1[`DATA_W]) rdq.push_back(bus_out);
            stage1 <= stage0;
            stage0 <= {write_beat_in, read_beat_in, write_data_in};
        end
    end
    // Write data is held past its capturing edge, then released at the falling edge.
    always @(negedge clk_in) begin
        driving <= stage1[`DATA_W+1];
        held <= stage1[`DATA_W-1:0];
    end
    // A released bus shows the inverse of its last level, so stale data never passes as a read.
    assign bus_out = dev_oe_in ? dev_data_in : driving ? held : ~last;
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the pipelined burst SRAM port.
// Assumes the port, its bound monitor and the controller model; inputs change on falling edges.
`include "sram_port_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, qual_n = 1'b1, ld = 1'b0, rnw = 1'b1, oe_n = 1'b0;
    logic sleep = 1'b0, order = 1'b0, pw = 1'b0, pr = 1'b0, oe, ready;
    logic [2:0] cs = 3'h2;
    logic [`ADDR_W-1:0] addr = `ADDR_ZERO;
    logic [`MASK_W-1:0] lanes_n = `MASK_NONE;
    logic [`DATA_W-1:0] wdata = `DATA_ZERO, bus, dout;
    logic [`DATA_W-1:0] mem [logic [`ADDR_W-1:0]];
    logic [`DATA_W-1:0] exp_q [$];
    logic [15:0] seq_no = 16'h0001;
    int failures = 0, compares = 0;
    initial forever #10 clk = ~clk;
    pipelined_burst_sram_port u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .CLOCK_QUALIFY_N_IN(qual_n),
        .CHIP_SELECT_FIRST_N_IN(cs[2]), .CHIP_SELECT_SECOND_IN(cs[1]), .CHIP_SELECT_THIRD_N_IN(cs[0]),
        .LOAD_OR_ADVANCE_IN(ld), .READ_NOT_WRITE_IN(rnw), .BYTE_LANE_WRITE_N_IN(lanes_n),
        .OUTPUT_ENABLE_N_IN(oe_n), .SLEEP_REQUEST_IN(sleep), .BURST_ORDER_IN(order), .DATA_IN(bus),
        .DATA_OUT(dout), .DATA_OE_OUT(oe), .WRITE_QUEUE_READY_OUT(ready));
    sram_ctrl_model u_ctrl (.clk_in(clk), .qualify_n_in(qual_n), .ready_in(ready), .write_beat_in(pw),
        .read_beat_in(pr), .write_data_in(wdata), .dev_data_in(dout), .dev_oe_in(oe), .bus_out(bus));
    // ============================================================
    // Compare and report
    task automatic check_word(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ============================================================
    // Bus beats
    // One beat is driven and held until an edge accepts it; a full queue may hold it off.
    task automatic beat(input logic l, input logic r, input logic [2:0] c, input logic [`ADDR_W-1:0] a,
            input logic [`MASK_W-1:0] m, input logic [`DATA_W-1:0] d, input logic wb, input logic rb);
        int n;
        logic ok;
        @(negedge clk);
        qual_n = 1'b0;
        ld = l;
        rnw = r;
        cs = c;
        addr = a;
        lanes_n = m;
        wdata = d;
        pw = wb;
        pr = rb;
        // Ready is read before the edge, since that very edge may change it.
        for (n = 0; n < 50; n++) begin
            ok = ready;
            @(posedge clk);
            if (ok === 1'b1) break;
            @(negedge clk);
        end
        if (n == 50) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic acc(input logic l, input logic w, input logic [`ADDR_W-1:0] a, input logic [`MASK_W-1:0] m);
        logic [`DATA_W-1:0] d;
        d = {a[19:0], seq_no};
        seq_no++;
        beat(l, !w, 3'h2, a, m, d, w, !w);
        if (w) begin
            for (int k = 0; k < `LANES; k++) if (!m[k]) mem[a][k*`LANE_W +: `LANE_W] = d[k*`LANE_W +: `LANE_W];
        end else exp_q.push_back(mem[a]);
    endtask
    task automatic nop;
        beat(1'b0, 1'b1, 3'h6, `ADDR_ZERO, `MASK_NONE, `DATA_ZERO, 1'b0, 1'b0);
    endtask
    task automatic drain(input string name);
        nop();
        nop();
        @(negedge clk);
        check_bit(u_ctrl.rdq.size() == exp_q.size(), 1'b1);
        while (exp_q.size() > 0 && u_ctrl.rdq.size() > 0) check_word(u_ctrl.rdq.pop_front(), exp_q.pop_front());
        exp_q.delete();
        u_ctrl.rdq.delete();
        $display("test %s done", name);
    endtask
    // ============================================================
    // Scenarios
    // Five beats from one address, so the last beat shows the wrap inside the group.
    task automatic t_burst(input logic w, input logic ilv, input logic [1:0] st, input logic [`ADDR_W-1:0] base);
        logic [1:0] k;
        // Clock qualify goes high so the previous beat is not taken a second time.
        @(negedge clk);
        qual_n = 1'b1;
        order = ilv;
        for (int i = 0; i < 5; i++) begin
            k = ilv ? st ^ i[1:0] : st + i[1:0];
            acc(i != 0, w, {base[`ADDR_W-1:2], k}, `MASK_NONE);
        end
    endtask
    task automatic t_lanes;
        acc(1'b0, 1'b1, 21'h00_0040, `MASK_NONE);
        acc(1'b0, 1'b1, 21'h00_0040, 4'hA);
        acc(1'b0, 1'b0, 21'h00_0040, `MASK_NONE);
        drain("lanes");
    endtask
    // A write offered while clock qualify is high must leave the word untouched.
    task automatic t_stall;
        acc(1'b0, 1'b0, 21'h00_0040, `MASK_NONE);
        @(negedge clk);
        qual_n = 1'b1;
        ld = 1'b0;
        rnw = 1'b0;
        repeat (3) @(negedge clk);
        acc(1'b0, 1'b0, 21'h00_0040, `MASK_NONE);
        drain("stall");
    endtask
    task automatic t_deselect;
        for (int i = 0; i < 3; i++) begin
            acc(1'b0, 1'b0, 21'h00_1235, `MASK_NONE);
            beat(1'b0, 1'b1, 3'h2 ^ (3'h1 << i), `ADDR_ZERO, `MASK_NONE, `DATA_ZERO, 1'b0, 1'b0);
            beat(1'b1, 1'b1, 3'h2, `ADDR_ZERO, `MASK_NONE, `DATA_ZERO, 1'b0, 1'b0);
            nop();
            @(negedge clk);
            check_bit(oe, 1'b0);
        end
        drain("deselect");
    endtask
    task automatic t_oe;
        // The enable is pulsed inside one cycle, so the read data is intact at its sampling edge.
        acc(1'b0, 1'b0, 21'h00_1236, `MASK_NONE);
        nop();
        @(negedge clk);
        oe_n = 1'b1;
        #1;
        check_bit(oe, 1'b0);
        oe_n = 1'b0;
        #1;
        check_bit(oe, 1'b1);
        drain("oe");
    endtask
    // Sleep stops the array writes, so eight writes fill the queue until it refuses.
    task automatic t_sleep;
        int n;
        @(negedge clk);
        sleep = 1'b1;
        for (int i = 0; i < 8; i++) acc(1'b0, 1'b1, {18'h0_0020, i[2:0]}, `MASK_NONE);
        nop();
        nop();
        @(negedge clk);
        check_bit(ready, 1'b0);
        sleep = 1'b0;
        for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge clk);
        check_bit(ready, 1'b1);
        for (int i = 0; i < 8; i++) acc(1'b0, 1'b0, {18'h0_0020, i[2:0]}, `MASK_NONE);
        drain("sleep");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_burst(1'b1, 1'b0, 2'h3, 21'h00_1234);
        t_burst(1'b0, 1'b0, 2'h2, 21'h00_1234);
        t_burst(1'b0, 1'b1, 2'h1, 21'h00_1234);
        t_burst(1'b1, 1'b1, 2'h2, 21'h00_5678);
        t_burst(1'b0, 1'b0, 2'h0, 21'h00_5678);
        drain("burst");
        t_lanes();
        t_stall();
        t_deselect();
        t_oe();
        t_sleep();
        end_of_test();
    end
endmodule
